// [crc_regs_pkg.sv]
// Purpose: shared constants for the crc result and polynomial register block
// Assumes: axi4-lite, 32-bit data, one register per aligned word
// Notes: offsets are local choices
`default_nettype none
package crc_regs_pkg;
   localparam int ADDR_W = 8;
   localparam int CRC_W = 16;
   localparam logic [ADDR_W-1:0] OFF_SUM_HIGH = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SUM_LOW = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STAGE_HIGH = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STAGE_LOW = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_TAPS_HIGH = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_TAPS_LOW = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_INPUT_LOW = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_POLY_LEN = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
   localparam logic [15:0] SUM_RESET = 16'h0000;
   localparam logic [15:0] STAGE_RESET = 16'h0000;
   localparam logic [15:0] TAPS_RESET = 16'h0001;
   localparam logic [3:0] POLY_LEN_RESET = 4'hF;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : crc_regs_pkg
`default_nettype wire

// [crc_shift_engine.sv]
// Purpose: serial crc engine, one data bit per clock into the running sum
// Assumes: msb-first shifting; poly_len holds length minus one
// Notes: load and sum write never collide; the top module orders them
`timescale 1ns/1ps
`default_nettype none
module crc_shift_engine
   import crc_regs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [7:0] load_byte,
   input wire logic sum_we,
   input wire logic [15:0] sum_wdata,
   input wire logic [15:0] taps,
   input wire logic [3:0] poly_len,
   output logic [15:0] sum,
   output logic [15:0] stage,
   output logic busy
);
   logic [3:0] left;
   logic fb;
   logic [15:0] next_sum;

   // ----------------------------------------
   // feedback step
   // ----------------------------------------
   always_comb begin
      fb = sum[poly_len] ^ stage[7];
      next_sum = sum << 1;
      next_sum[0] = fb;
      for (int i = 1; i < CRC_W; i++) begin
         // cleared taps pass the shifted bit straight through
         if (taps[i] && (4'(i) <= poly_len)) begin
            next_sum[i] = sum[i-1] ^ fb;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sum <= SUM_RESET;
      end else if (sum_we) begin
         sum <= sum_wdata;
      end else if (busy) begin
         sum <= next_sum;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stage <= STAGE_RESET;
         left <= 4'h0;
         busy <= 1'b0;
      end else if (load) begin
         stage <= {8'h00, load_byte};
         left <= BITS_PER_BYTE;
         busy <= 1'b1;
      end else if (busy) begin
         stage <= {stage[14:0], 1'b0};
         left <= left - 4'h1;
         busy <= (left != 4'h1);
      end
   end
endmodule : crc_shift_engine
`default_nettype wire

// [crc_result_and_poly_regs.sv]
// Purpose: axi4-lite register block for crc running sum, shifter view, taps
// Assumes: single clock, synchronous active-low reset
// Notes: one write and one read outstanding at most
`timescale 1ns/1ps
`default_nettype none
module crc_result_and_poly_regs
   import crc_regs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [ADDR_W-1:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic [15:0] taps;
   logic [3:0] poly_len;
   logic [15:0] sum;
   logic [15:0] stage;
   logic busy;
   logic do_write;
   logic write_ok;
   logic sum_we;
   logic [15:0] sum_wdata;
   logic load;
   logic [31:0] next_rdata;
   logic read_ok;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFF_SUM_HIGH) || (a == OFF_SUM_LOW) || (a == OFF_STAGE_HIGH)
         || (a == OFF_STAGE_LOW) || (a == OFF_TAPS_HIGH) || (a == OFF_TAPS_LOW)
         || (a == OFF_INPUT_LOW) || (a == OFF_POLY_LEN) || (a == OFF_STATUS);
   endfunction : mapped

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   // a write waits while the engine shifts so the sum is never torn
   assign do_write = aw_held && w_held && !s_axi_bvalid && !busy;
   assign write_ok = mapped(aw_addr);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_comb begin
      sum_we = 1'b0;
      sum_wdata = sum;
      if (do_write && w_strb[0]) begin
         if (aw_addr == OFF_SUM_HIGH) begin
            sum_we = 1'b1;
            sum_wdata = {w_data[7:0], sum[7:0]};
         end else if (aw_addr == OFF_SUM_LOW) begin
            sum_we = 1'b1;
            sum_wdata = {sum[15:8], w_data[7:0]};
         end
      end
   end

   assign load = do_write && w_strb[0] && (aw_addr == OFF_INPUT_LOW);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         taps <= TAPS_RESET;
         poly_len <= POLY_LEN_RESET;
      end else if (do_write && w_strb[0]) begin
         if (aw_addr == OFF_TAPS_HIGH) begin
            taps[15:8] <= w_data[7:0];
         end
         if (aw_addr == OFF_TAPS_LOW) begin
            taps[7:0] <= {w_data[7:1], 1'b1};
         end
         if (aw_addr == OFF_POLY_LEN) begin
            poly_len <= w_data[3:0];
         end
      end
   end

   crc_shift_engine u_engine (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .load(load),
      .load_byte(w_data[7:0]),
      .sum_we(sum_we),
      .sum_wdata(sum_wdata),
      .taps(taps),
      .poly_len(poly_len),
      .sum(sum),
      .stage(stage),
      .busy(busy)
   );

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always_comb begin
      next_rdata = 32'h00000000;
      read_ok = 1'b1;
      case (s_axi_araddr)
         OFF_SUM_HIGH: next_rdata[7:0] = sum[15:8];
         OFF_SUM_LOW: next_rdata[7:0] = sum[7:0];
         OFF_STAGE_HIGH: next_rdata[7:0] = stage[15:8];
         OFF_STAGE_LOW: next_rdata[7:0] = stage[7:0];
         OFF_TAPS_HIGH: next_rdata[7:0] = taps[15:8];
         OFF_TAPS_LOW: next_rdata[7:0] = {taps[7:1], 1'b1};
         OFF_INPUT_LOW: next_rdata[7:0] = stage[7:0];
         OFF_POLY_LEN: next_rdata[3:0] = poly_len;
         OFF_STATUS: next_rdata[0] = busy;
         default: read_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_sum_high_write;
      @(posedge clk_sys) disable iff (!rst_n)
         (do_write && w_strb[0] && aw_addr == OFF_SUM_HIGH) |=> (sum[15:8] == $past(w_data[7:0]));
   endproperty
   a_sum_high_write: assert property (p_sum_high_write) else $error("sum high byte not loaded");

   property p_sum_low_write;
      @(posedge clk_sys) disable iff (!rst_n)
         (do_write && w_strb[0] && aw_addr == OFF_SUM_LOW)
         |=> (sum == {$past(sum[15:8]), $past(w_data[7:0])});
   endproperty
   a_sum_low_write: assert property (p_sum_low_write) else $error("sum low byte not loaded");

   property p_sum_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_SUM_LOW)
         |=> (s_axi_rdata == {24'h000000, $past(sum[7:0])});
   endproperty
   a_sum_read: assert property (p_sum_read) else $error("sum low read wrong");

   property p_stage_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STAGE_HIGH)
         |=> (s_axi_rdata[7:0] == $past(stage[15:8]));
   endproperty
   a_stage_read: assert property (p_stage_read) else $error("shifter high read wrong");

   property p_stage_ro;
      @(posedge clk_sys) disable iff (!rst_n)
         (!busy && !load) |=> (stage == $past(stage));
   endproperty
   a_stage_ro: assert property (p_stage_ro) else $error("shifter changed by a write");

   property p_taps_high;
      @(posedge clk_sys) disable iff (!rst_n)
         (do_write && w_strb[0] && aw_addr == OFF_TAPS_HIGH) |=> (taps[15:8] == $past(w_data[7:0]));
   endproperty
   a_taps_high: assert property (p_taps_high) else $error("tap high byte not loaded");

   property p_taps_low;
      @(posedge clk_sys) disable iff (!rst_n)
         (do_write && w_strb[0] && aw_addr == OFF_TAPS_LOW) |=> (taps[7:1] == $past(w_data[7:1]));
   endproperty
   a_taps_low: assert property (p_taps_low) else $error("tap low bits not loaded");

   property p_tap0_one;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_TAPS_LOW) |=> (s_axi_rdata[0] && taps[0]);
   endproperty
   a_tap0_one: assert property (p_tap0_one) else $error("tap bit zero not one");

   property p_load_shift;
      @(posedge clk_sys) disable iff (!rst_n)
         load |=> busy [*8] ##1 !busy;
   endproperty
   a_load_shift: assert property (p_load_shift) else $error("shift did not last eight cycles");

   property p_plain_tap;
      @(posedge clk_sys) disable iff (!rst_n)
         (busy && !sum_we && !taps[1]) |=> (sum[1] == $past(sum[0]));
   endproperty
   a_plain_tap: assert property (p_plain_tap) else $error("cleared tap applied feedback");

   property p_feedback_top;
      @(posedge clk_sys) disable iff (!rst_n)
         (busy && !sum_we) |=> (sum[0] == ($past(sum[poly_len]) ^ $past(stage[7])));
   endproperty
   a_feedback_top: assert property (p_feedback_top) else $error("feedback not from top term");

   property p_sum_hold;
      @(posedge clk_sys) disable iff (!rst_n)
         (!busy && !sum_we) |=> (sum == $past(sum));
   endproperty
   a_sum_hold: assert property (p_sum_hold) else $error("sum changed without write or shift");

   property p_sum_high_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_SUM_HIGH)
         |=> (s_axi_rdata == {24'h000000, $past(sum[15:8])});
   endproperty
   a_sum_high_read: assert property (p_sum_high_read) else $error("sum high read wrong");

   property p_stage_low_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STAGE_LOW)
         |=> (s_axi_rdata == {24'h000000, $past(stage[7:0])});
   endproperty
   a_stage_low_read: assert property (p_stage_low_read) else $error("shifter low read wrong");

   property p_stage_reset;
      @(posedge clk_sys) disable iff (!rst_n)
         $rose(rst_n) |-> (stage == STAGE_RESET);
   endproperty
   a_stage_reset: assert property (p_stage_reset) else $error("shifter not zero after reset");

   property p_stage_write_ignored;
      @(posedge clk_sys) disable iff (!rst_n)
         (do_write && (aw_addr == OFF_STAGE_HIGH || aw_addr == OFF_STAGE_LOW))
         |=> (stage == $past(stage) && s_axi_bresp == RESP_OKAY);
   endproperty
   a_stage_write_ignored: assert property (p_stage_write_ignored) else $error("shifter view took a write");

   property p_taps_high_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_TAPS_HIGH)
         |=> (s_axi_rdata == {24'h000000, $past(taps[15:8])});
   endproperty
   a_taps_high_read: assert property (p_taps_high_read) else $error("tap high read wrong");

   property p_taps_low_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_TAPS_LOW)
         |=> (s_axi_rdata[7:1] == $past(taps[7:1]));
   endproperty
   a_taps_low_read: assert property (p_taps_low_read) else $error("tap low read wrong");

   property p_load_stage;
      @(posedge clk_sys) disable iff (!rst_n)
         load |=> (stage == {8'h00, $past(w_data[7:0])});
   endproperty
   a_load_stage: assert property (p_load_stage) else $error("shifter not loaded from input");

   property p_stage_shift;
      @(posedge clk_sys) disable iff (!rst_n)
         busy |=> (stage == {$past(stage[14:0]), 1'b0});
   endproperty
   a_stage_shift: assert property (p_stage_shift) else $error("shifter did not move one place");

   property p_upper_plain;
      @(posedge clk_sys) disable iff (!rst_n)
         (busy && poly_len < 4'hF) |=> (sum[15] == $past(sum[14]));
   endproperty
   a_upper_plain: assert property (p_upper_plain) else $error("bit above length got feedback");

   property p_len_write;
      @(posedge clk_sys) disable iff (!rst_n)
         (do_write && w_strb[0] && aw_addr == OFF_POLY_LEN) |=> (poly_len == $past(w_data[3:0]));
   endproperty
   a_len_write: assert property (p_len_write) else $error("length field not loaded");
endmodule : crc_result_and_poly_regs
`default_nettype wire

// [crc_result_and_poly_regs_test.sv]
// Purpose: self-checking bench for the crc running sum, shifter view and tap registers
// Assumes: axi4-lite master driven at rising edges, byte lane 0 carries register data
// Notes: crc expectations come from a local bit-serial model, msb first
`timescale 1ns/1ps
`default_nettype none
module crc_result_and_poly_regs_test
   import crc_regs_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [31:0] rd_val;
   logic [1:0] resp;

   crc_result_and_poly_regs uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // reporting
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // hang guard: whole run needs a few hundred cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1;
         end
      end
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1;
         end
      end
   endtask : rd

   task automatic wr_ok(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      wr(a, {24'h000000, d}, 4'h1, resp);
   endtask : wr_ok

   task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      rd(a, rd_val, resp);
      check(name, rd_val, {24'h000000, exp});
   endtask : rd_chk

   // independent serial model: left shift, feedback into bit 0, taps 1..poly_length_field
   function automatic logic [15:0] crc_model(input logic [15:0] s, input logic [7:0] b,
                                            input logic [15:0] t, input logic [3:0] p);
      logic [15:0] n;
      logic fb;
      for (int k = 7; k >= 0; k--) begin
         fb = b[k] ^ s[p];
         n[0] = fb;
         for (int i = 1; i < 16; i++) n[i] = s[i-1] ^ ((i <= int'(p)) && t[i] && fb);
         s = n;
      end
      return s;
   endfunction : crc_model

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reset_values();
      rd_chk("sum_high", OFF_SUM_HIGH, 8'h00);
      rd_chk("sum_low", OFF_SUM_LOW, 8'h00);
      rd_chk("stage_high", OFF_STAGE_HIGH, 8'h00);
      rd_chk("stage_low", OFF_STAGE_LOW, 8'h00);
      rd_chk("taps_low", OFF_TAPS_LOW, 8'h01);
      rd_chk("poly_len", OFF_POLY_LEN, 8'h0F);
   endtask : reset_values

   task automatic sum_access();
      wr_ok(OFF_SUM_HIGH, 8'hA5);
      check("sum_high_resp", {30'h0, resp}, {30'h0, RESP_OKAY});
      wr_ok(OFF_SUM_LOW, 8'h3C);
      rd_chk("sum_high", OFF_SUM_HIGH, 8'hA5);
      rd_chk("sum_low", OFF_SUM_LOW, 8'h3C);
      rd_chk("sum_high_again", OFF_SUM_HIGH, 8'hA5);
      rd_chk("sum_low_again", OFF_SUM_LOW, 8'h3C);
      // byte lane 0 not enabled: register must keep its value
      wr(OFF_SUM_LOW, 32'h000000FF, 4'h0, resp);
      rd_chk("sum_low_nostrb", OFF_SUM_LOW, 8'h3C);
   endtask : sum_access

   task automatic read_only_places();
      wr_ok(OFF_STAGE_HIGH, 8'hFF);
      check("stage_high_wresp", {30'h0, resp}, {30'h0, RESP_OKAY});
      wr_ok(OFF_STAGE_LOW, 8'hFF);
      rd_chk("stage_high_ro", OFF_STAGE_HIGH, 8'h00);
      rd_chk("stage_low_ro", OFF_STAGE_LOW, 8'h00);
      wr_ok(8'h40, 8'h55);
      check("unmapped_wresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      rd(8'h40, rd_val, resp);
      check("unmapped_rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      rd_chk("sum_untouched", OFF_SUM_HIGH, 8'hA5);
   endtask : read_only_places

   task automatic tap_access();
      wr_ok(OFF_TAPS_HIGH, 8'h81);
      rd_chk("taps_high", OFF_TAPS_HIGH, 8'h81);
      wr_ok(OFF_TAPS_LOW, 8'h04);
      rd_chk("taps_low_bit0", OFF_TAPS_LOW, 8'h05);
      wr_ok(OFF_TAPS_LOW, 8'hFE);
      rd_chk("taps_low", OFF_TAPS_LOW, 8'hFF);
   endtask : tap_access

   task automatic crc_run(input logic [15:0] s0, input logic [7:0] b, input logic [15:0] t,
                          input logic [3:0] p);
      logic [15:0] exp;
      int n;
      exp = crc_model(s0, b, t, p);
      wr_ok(OFF_SUM_HIGH, s0[15:8]);
      wr_ok(OFF_SUM_LOW, s0[7:0]);
      wr_ok(OFF_TAPS_HIGH, t[15:8]);
      wr_ok(OFF_TAPS_LOW, t[7:0]);
      wr_ok(OFF_POLY_LEN, {4'h0, p});
      wr_ok(OFF_INPUT_LOW, b);
      n = 0;
      // poll instead of a fixed wait: the engine's busy span is its own business
      do begin
         rd(OFF_STATUS, rd_val, resp);
         n++;
      end while (rd_val[0] !== 1'b0 && n < 40);
      check("busy_clear", rd_val, 32'h00000000);
      rd_chk("crc_high", OFF_SUM_HIGH, exp[15:8]);
      rd_chk("crc_low", OFF_SUM_LOW, exp[7:0]);
      rd_chk("stage_high_live", OFF_STAGE_HIGH, b);
      rd_chk("stage_low_live", OFF_STAGE_LOW, 8'h00);
   endtask : crc_run

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      reset_values();
      sum_access();
      read_only_places();
      tap_access();
      crc_run(16'h0000, 8'hA5, 16'h1021, 4'hF);
      crc_run(16'hFFFF, 8'h3C, 16'h0001, 4'hF);
      crc_run(16'h1234, 8'hC3, 16'h00A7, 4'h7);
      crc_run(16'h8001, 8'hFF, 16'h80FE, 4'hF);
      conclude();
   end
endmodule : crc_result_and_poly_regs_test
`default_nettype wire
